// ---- core/sfa_pkg.sv ----
/*
 * Shared constants of the saturating fixed-point ALU: operation codes,
 * saturation limits, shift caps and rounding constants.
 * Assumes a single clock domain and a controller that drives the codes below.
 */
package sfa_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Operation select codes
    localparam int SFA_OPW = 6;
    localparam logic [5:0] SFA_OP_ADD16 = 6'h00;
    localparam logic [5:0] SFA_OP_SUB16 = 6'h01;
    localparam logic [5:0] SFA_OP_ABS16 = 6'h02;
    localparam logic [5:0] SFA_OP_SHL16 = 6'h03;
    localparam logic [5:0] SFA_OP_SHR16 = 6'h04;
    localparam logic [5:0] SFA_OP_NEG16 = 6'h05;
    localparam logic [5:0] SFA_OP_MAX16 = 6'h06;
    localparam logic [5:0] SFA_OP_MIN16 = 6'h07;
    localparam logic [5:0] SFA_OP_NORM16 = 6'h08;
    localparam logic [5:0] SFA_OP_ADD32 = 6'h09;
    localparam logic [5:0] SFA_OP_SUB32 = 6'h0a;
    localparam logic [5:0] SFA_OP_ABS32 = 6'h0b;
    localparam logic [5:0] SFA_OP_SHL32 = 6'h0c;
    localparam logic [5:0] SFA_OP_SHR32 = 6'h0d;
    localparam logic [5:0] SFA_OP_NEG32 = 6'h0e;
    localparam logic [5:0] SFA_OP_MAX32 = 6'h0f;
    localparam logic [5:0] SFA_OP_MIN32 = 6'h10;
    localparam logic [5:0] SFA_OP_NORM32 = 6'h11;
    localparam logic [5:0] SFA_OP_IMUL16 = 6'h12;
    localparam logic [5:0] SFA_OP_MIXED_PRODUCT = 6'h13;
    localparam logic [5:0] SFA_OP_FRAC_PRODUCT = 6'h14;
    localparam logic [5:0] SFA_OP_PLAIN_LONG_PRODUCT = 6'h15;
    localparam logic [5:0] SFA_OP_SCALED_PRODUCT = 6'h16;
    localparam logic [5:0] SFA_OP_SCALED_PRODUCT_RND = 6'h17;
    localparam logic [5:0] SFA_OP_ACCUMULATE = 6'h18;
    localparam logic [5:0] SFA_OP_DEDUCT = 6'h19;
    localparam logic [5:0] SFA_OP_PLAIN_ACCUMULATE = 6'h1a;
    localparam logic [5:0] SFA_OP_PLAIN_DEDUCT = 6'h1b;
    localparam logic [5:0] SFA_OP_WRAPPING_ACCUMULATE_WITH_FLAGS = 6'h1c;
    localparam logic [5:0] SFA_OP_WRAPPING_DEDUCT_WITH_FLAGS = 6'h1d;
    localparam logic [5:0] SFA_OP_ACCUMULATE_RND = 6'h1e;
    localparam logic [5:0] SFA_OP_DEDUCT_RND = 6'h1f;
    localparam logic [5:0] SFA_OP_AND16 = 6'h20;
    localparam logic [5:0] SFA_OP_OR16 = 6'h21;
    localparam logic [5:0] SFA_OP_XOR16 = 6'h22;
    localparam logic [5:0] SFA_OP_LSHL16 = 6'h23;
    localparam logic [5:0] SFA_OP_LSHR16 = 6'h24;
    localparam logic [5:0] SFA_OP_AND32 = 6'h25;
    localparam logic [5:0] SFA_OP_OR32 = 6'h26;
    localparam logic [5:0] SFA_OP_XOR32 = 6'h27;
    localparam logic [5:0] SFA_OP_LSHL32 = 6'h28;
    localparam logic [5:0] SFA_OP_LSHR32 = 6'h29;

    ////////////////////////////////////////////////////////////////////////////
    // Limits and constants
    localparam logic signed [63:0] SFA_MAX16 = 64'sh0000_0000_0000_7fff;
    localparam logic signed [63:0] SFA_MIN16 = -64'sh0000_0000_0000_8000;
    localparam logic signed [63:0] SFA_MAX32 = 64'sh0000_0000_7fff_ffff;
    localparam logic signed [63:0] SFA_MIN32 = -64'sh0000_0000_8000_0000;
    localparam logic signed [63:0] SFA_RND_SCALED = 64'sh0000_0000_0000_4000;
    localparam logic signed [63:0] SFA_RND_ACC = 64'sh0000_0000_0000_8000;
    localparam int SFA_SCALE_SHIFT = 15;
    localparam int SFA_ACC_HI = 16;
    localparam logic [16:0] SFA_LEFT_CAP = 17'h00020;
    localparam logic [16:0] SFA_RIGHT_CAP = 17'h0003f;
    localparam logic [5:0] SFA_LOG_CAP = 6'h20;
    localparam logic [31:0] SFA_RES_RST = 32'h0000_0000;

endpackage : sfa_pkg

// ---- core/sfa_alu.sv ----
/*
 * Saturating fixed-point ALU: 16- and 32-bit saturating arithmetic, shifts,
 * normalisation, multiplies, accumulates and bitwise logic, one result per
 * accepted request after one clock.
 * Assumes a controller on the same clock that holds operands with the select.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Operands are signed two's complement; short is 16 bits, long is 32.
// - Short add and subtract clamp to +32767 and -32768.
// - Short absolute value maps -32768 to 32767.
// - Short left shift zero-fills; negative count shifts right sign-extending; saturates.
// - Short right shift sign-extends; negative count is left shift by magnitude; saturates.
// - Short negate equals saturating subtraction from zero.
// - Short and long max and min return the larger or smaller signed operand.
// - Short normalisation count brings operand into 16384..32767 or -32768..-16385.
// - Long add and subtract clamp to +2147483647 and -2147483648.
// - Long absolute value maps the most negative input to 2147483647.
// - Long arithmetic shifts behave like short ones and saturate.
// - Long negate saturates, -2147483648 gives the long maximum.
// - Long normalisation count targets 1073741824..2147483647 or its negative range.
// - Integer short product saturates to 16 bits; mixed long-by-short gives 32 bits.
// - Fractional long product is product doubled with saturation.
// - Plain long product is the unshifted 32-bit product.
// - Scaled short product is product shifted right 15, saturated to 16 bits.
// - Rounded scaled product adds 16384 before the 15-bit right shift.
// - Accumulate and deduct use fractional product with saturating long add/subtract.
// - Plain accumulate and deduct use the unshifted product, saturating.
// - Wrapping accumulate and deduct do not saturate and set carry and overflow.
// - Rounding accumulate and deduct saturate, add 32768, return upper 16 bits.
// - Bitwise AND, OR, XOR act per bit for short and long pairs.
// - Logical shifts zero-fill downward, shift upward unsaturated; negative count reverses.
// - Carry and overflow are single bits the controller can read and overwrite.
module sfa_alu
    import sfa_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [5:0] i_op,
    input wire logic [15:0] i_a16,
    input wire logic [15:0] i_b16,
    input wire logic [31:0] i_a32,
    input wire logic [31:0] i_b32,
    input wire logic [15:0] i_cnt,
    input wire logic i_carry_wr,
    input wire logic i_carry_val,
    input wire logic i_ovf_wr,
    input wire logic i_ovf_val,
    output logic o_valid,
    output logic [31:0] o_res,
    output logic o_carry,
    output logic o_ovf
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] sfa_sat16(input logic signed [63:0] v);
        if (v > SFA_MAX16) begin
            return SFA_MAX16[15:0];
        end else if (v < SFA_MIN16) begin
            return SFA_MIN16[15:0];
        end
        return v[15:0];
    endfunction : sfa_sat16

    function automatic logic [31:0] sfa_sat32(input logic signed [63:0] v);
        if (v > SFA_MAX32) begin
            return SFA_MAX32[31:0];
        end else if (v < SFA_MIN32) begin
            return SFA_MIN32[31:0];
        end
        return v[31:0];
    endfunction : sfa_sat32

    // Positive count shifts left, negative shifts right with sign. The caps keep the
    // shifter narrow; any nonzero value shifted past the width saturates anyway.
    function automatic logic signed [63:0] sfa_ashift(input logic signed [63:0] v,
                                                     input logic signed [16:0] n);
        logic [16:0] mag;
        mag = n[16] ? 17'(-n) : 17'(n);
        if (!n[16]) begin
            if (mag > SFA_LEFT_CAP) begin
                mag = SFA_LEFT_CAP;
            end
            return v <<< mag[5:0];
        end
        if (mag > SFA_RIGHT_CAP) begin
            mag = SFA_RIGHT_CAP;
        end
        return v >>> mag[5:0];
    endfunction : sfa_ashift

    // Logical shift: zero fill both ways, no saturation, result cut to the operand width.
    function automatic logic [31:0] sfa_lshift(input logic [31:0] v, input logic signed [16:0] n);
        logic [16:0] mag;
        logic [5:0] sh;
        mag = n[16] ? 17'(-n) : 17'(n);
        sh = (mag >= {11'h000, SFA_LOG_CAP}) ? SFA_LOG_CAP : mag[5:0];
        if (sh == SFA_LOG_CAP) begin
            return 32'h0000_0000;
        end
        return n[16] ? (v >> sh) : (v << sh);
    endfunction : sfa_lshift

    // Count of redundant sign bits below the top bit; zero gives zero.
    function automatic logic [4:0] sfa_norm(input logic [31:0] v);
        logic [4:0] c;
        logic done;
        c = 5'h00;
        done = 1'b0;
        for (int i = 30; i >= 0; i--) begin
            if (!done && (v[i] == v[31])) begin
                c = c + 5'h01;
            end else begin
                done = 1'b1;
            end
        end
        if (v == 32'h0000_0000) begin
            c = 5'h00;
        end
        return c;
    endfunction : sfa_norm

    ////////////////////////////////////////////////////////////////////////////
    // Operand views

    logic signed [63:0] a16_w;
    logic signed [63:0] b16_w;
    logic signed [63:0] a32_w;
    logic signed [63:0] b32_w;
    logic signed [16:0] cnt_pos;
    logic signed [16:0] cnt_neg;
    logic signed [31:0] prod16;
    logic signed [63:0] prod_w;
    logic signed [63:0] frac_w;
    logic signed [63:0] mixed_w;
    logic [31:0] frac_sat;

    assign a16_w = 64'(signed'(i_a16));
    assign b16_w = 64'(signed'(i_b16));
    assign a32_w = 64'(signed'(i_a32));
    assign b32_w = 64'(signed'(i_b32));
    assign cnt_pos = 17'(signed'(i_cnt));
    // Widened first so that the most negative count still negates cleanly
    assign cnt_neg = -cnt_pos;
    assign prod16 = signed'(i_a16) * signed'(i_b16);
    assign prod_w = 64'(prod16);
    assign frac_sat = sfa_sat32(prod_w <<< 1);
    assign frac_w = 64'(signed'(frac_sat));
    assign mixed_w = a32_w * b16_w;

    // Short logical shifts run in a 32-bit frame, so that counts of 16 to 31
    // still clear every bit instead of wrapping the shift amount.
    logic [31:0] lsh16_up;
    logic [31:0] lsh16_dn;

    assign lsh16_up = sfa_lshift({16'h0000, i_a16}, cnt_pos);
    assign lsh16_dn = sfa_lshift({16'h0000, i_a16}, cnt_neg);

    ////////////////////////////////////////////////////////////////////////////
    // Wrapping accumulate with carry and overflow

    logic [32:0] wrap_sum;
    logic [31:0] wrap_rhs;
    logic wrap_sub;
    logic wrap_ovf;

    // Carry is the true carry out, or no-borrow for the deduct form; carry-in
    // is never used, so a stale flag cannot leak into the sum.
    assign wrap_sub = (i_op == SFA_OP_WRAPPING_DEDUCT_WITH_FLAGS);
    assign wrap_rhs = wrap_sub ? ~frac_sat : frac_sat;
    assign wrap_sum = {1'b0, i_b32} + {1'b0, wrap_rhs} + {32'h0000_0000, wrap_sub};
    assign wrap_ovf = (i_b32[31] == wrap_rhs[31]) && (wrap_sum[31] != i_b32[31]);

    ////////////////////////////////////////////////////////////////////////////
    // Result select

    logic [31:0] res_nxt;
    logic [31:0] acc_sat;
    logic [31:0] acc_rnd;
    logic flags_upd;

    assign flags_upd = i_valid && ((i_op == SFA_OP_WRAPPING_ACCUMULATE_WITH_FLAGS) || wrap_sub);

    always_comb begin
        res_nxt = SFA_RES_RST;
        acc_sat = SFA_RES_RST;
        acc_rnd = SFA_RES_RST;
        case (i_op)
            SFA_OP_ADD16: res_nxt = 32'(signed'(sfa_sat16(a16_w + b16_w)));
            SFA_OP_SUB16: res_nxt = 32'(signed'(sfa_sat16(a16_w - b16_w)));
            SFA_OP_ABS16: res_nxt = 32'(signed'(sfa_sat16(i_a16[15] ? -a16_w : a16_w)));
            SFA_OP_SHL16: res_nxt = 32'(signed'(sfa_sat16(sfa_ashift(a16_w, cnt_pos))));
            SFA_OP_SHR16: res_nxt = 32'(signed'(sfa_sat16(sfa_ashift(a16_w, cnt_neg))));
            SFA_OP_NEG16: res_nxt = 32'(signed'(sfa_sat16(64'sh0 - a16_w)));
            SFA_OP_MAX16: res_nxt = 32'((a16_w > b16_w) ? a16_w : b16_w);
            SFA_OP_MIN16: res_nxt = 32'((a16_w < b16_w) ? a16_w : b16_w);
            SFA_OP_NORM16: res_nxt = {27'h0000000, sfa_norm({i_a16, 16'h0000})};
            SFA_OP_ADD32: res_nxt = sfa_sat32(a32_w + b32_w);
            SFA_OP_SUB32: res_nxt = sfa_sat32(a32_w - b32_w);
            SFA_OP_ABS32: res_nxt = sfa_sat32(i_a32[31] ? -a32_w : a32_w);
            SFA_OP_SHL32: res_nxt = sfa_sat32(sfa_ashift(a32_w, cnt_pos));
            SFA_OP_SHR32: res_nxt = sfa_sat32(sfa_ashift(a32_w, cnt_neg));
            SFA_OP_NEG32: res_nxt = sfa_sat32(64'sh0 - a32_w);
            SFA_OP_MAX32: res_nxt = (a32_w > b32_w) ? i_a32 : i_b32;
            SFA_OP_MIN32: res_nxt = (a32_w < b32_w) ? i_a32 : i_b32;
            SFA_OP_NORM32: res_nxt = {27'h0000000, sfa_norm(i_a32)};
            SFA_OP_IMUL16: res_nxt = 32'(signed'(sfa_sat16(prod_w)));
            SFA_OP_MIXED_PRODUCT: res_nxt = sfa_sat32(mixed_w);
            SFA_OP_FRAC_PRODUCT: res_nxt = frac_sat;
            SFA_OP_PLAIN_LONG_PRODUCT: res_nxt = prod16;
            SFA_OP_SCALED_PRODUCT: begin
                // Only -32768 squared lands outside 16 bits, and it saturates
                res_nxt = 32'(signed'(sfa_sat16(prod_w >>> SFA_SCALE_SHIFT)));
            end
            SFA_OP_SCALED_PRODUCT_RND: begin
                res_nxt = 32'(signed'(sfa_sat16((prod_w + SFA_RND_SCALED) >>> SFA_SCALE_SHIFT)));
            end
            SFA_OP_ACCUMULATE: res_nxt = sfa_sat32(b32_w + frac_w);
            SFA_OP_DEDUCT: res_nxt = sfa_sat32(b32_w - frac_w);
            SFA_OP_PLAIN_ACCUMULATE: res_nxt = sfa_sat32(b32_w + prod_w);
            SFA_OP_PLAIN_DEDUCT: res_nxt = sfa_sat32(b32_w - prod_w);
            SFA_OP_WRAPPING_ACCUMULATE_WITH_FLAGS: res_nxt = wrap_sum[31:0];
            SFA_OP_WRAPPING_DEDUCT_WITH_FLAGS: res_nxt = wrap_sum[31:0];
            SFA_OP_ACCUMULATE_RND: begin
                acc_sat = sfa_sat32(b32_w + frac_w);
                acc_rnd = sfa_sat32(64'(signed'(acc_sat)) + SFA_RND_ACC);
                // Upper half taken as a signed short, so the result sign-extends
                res_nxt = 32'(signed'(acc_rnd[31:SFA_ACC_HI]));
            end
            SFA_OP_DEDUCT_RND: begin
                acc_sat = sfa_sat32(b32_w - frac_w);
                acc_rnd = sfa_sat32(64'(signed'(acc_sat)) + SFA_RND_ACC);
                res_nxt = 32'(signed'(acc_rnd[31:SFA_ACC_HI]));
            end
            SFA_OP_AND16: res_nxt = 32'(signed'(i_a16 & i_b16));
            SFA_OP_OR16: res_nxt = 32'(signed'(i_a16 | i_b16));
            SFA_OP_XOR16: res_nxt = 32'(signed'(i_a16 ^ i_b16));
            SFA_OP_LSHL16: res_nxt = 32'(signed'(lsh16_up[15:0]));
            SFA_OP_LSHR16: res_nxt = 32'(signed'(lsh16_dn[15:0]));
            SFA_OP_AND32: res_nxt = i_a32 & i_b32;
            SFA_OP_OR32: res_nxt = i_a32 | i_b32;
            SFA_OP_XOR32: res_nxt = i_a32 ^ i_b32;
            SFA_OP_LSHL32: res_nxt = sfa_lshift(i_a32, cnt_pos);
            SFA_OP_LSHR32: res_nxt = sfa_lshift(i_a32, cnt_neg);
            default: res_nxt = SFA_RES_RST;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result register: one cycle of latency for every operation

    logic [31:0] res_r;
    logic valid_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= i_valid;
        end
    end

    // Result holds its last value while no request is taken
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            res_r <= SFA_RES_RST;
        end else if (i_valid) begin
            res_r <= res_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carry and overflow flags: an operation that updates them wins over a
    // controller write in the same cycle, so no event is lost.

    logic carry_r;
    logic ovf_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            carry_r <= 1'b0;
        end else if (flags_upd) begin
            carry_r <= wrap_sum[32];
        end else if (i_carry_wr) begin
            carry_r <= i_carry_val;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ovf_r <= 1'b0;
        end else if (flags_upd) begin
            ovf_r <= wrap_ovf;
        end else if (i_ovf_wr) begin
            ovf_r <= i_ovf_val;
        end
    end

    assign o_valid = valid_r;
    assign o_res = res_r;
    assign o_carry = carry_r;
    assign o_ovf = ovf_r;

endmodule : sfa_alu

// ---- verif/sfa_alu_checker.sv ----
/*
 * Checker on the ALU pins: result timing, clamp corners and flag writes.
 * Assumes it is bound to sfa_alu and sees only that module's ports.
 */
`timescale 1ns/1ps
module sfa_alu_checker
    import sfa_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [5:0] i_op,
    input wire logic [15:0] i_a16,
    input wire logic [15:0] i_b16,
    input wire logic [31:0] i_a32,
    input wire logic [31:0] i_b32,
    input wire logic [15:0] i_cnt,
    input wire logic i_carry_wr,
    input wire logic i_carry_val,
    input wire logic i_ovf_wr,
    input wire logic i_ovf_val,
    input wire logic o_valid,
    input wire logic [31:0] o_res,
    input wire logic o_carry,
    input wire logic o_ovf
);
    // A wrapping op wins over a flag write in the same cycle
    logic wrap_take;
    assign wrap_take = i_valid && (i_op == SFA_OP_WRAPPING_ACCUMULATE_WITH_FLAGS
        || i_op == SFA_OP_WRAPPING_DEDUCT_WITH_FLAGS);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_take(logic [5:0] code);
        i_valid && i_op == code;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    chk_valid_pulse: assert property (i_valid |=> o_valid) else $error("no result after request");
    chk_no_extra: assert property (!i_valid |=> !o_valid) else $error("result without request");
    chk_res_hold: assert property (!i_valid |=> $stable(o_res)) else $error("result moved while idle");
    chk_add16_clamp: assert property (s_take(SFA_OP_ADD16) ##0 (!i_a16[15] && !i_b16[15]
        && (17'(i_a16) + 17'(i_b16)) > 17'h07fff) |=> o_res == 32'h0000_7fff) else $error("short add not clamped");
    chk_abs16_min: assert property (s_take(SFA_OP_ABS16) ##0 i_a16 == 16'h8000
        |=> o_res == 32'h0000_7fff) else $error("short abs corner wrong");
    chk_frac_min: assert property (s_take(SFA_OP_FRAC_PRODUCT) ##0 (i_a16 == 16'h8000 && i_b16 == 16'h8000)
        |=> o_res == 32'h7fff_ffff) else $error("fractional corner wrong");
    chk_carry_write: assert property (i_carry_wr && !wrap_take |=> o_carry == $past(i_carry_val))
        else $error("carry write lost");
    // The overflow flag moves only on its write or a wrapping op, so a stray update shows here
    chk_ovf_hold: assert property (!i_ovf_wr && !wrap_take |=> $stable(o_ovf))
        else $error("overflow flag moved");
endmodule : sfa_alu_checker
////////////////////////////////////////////////////////////////////////////////
bind sfa_alu sfa_alu_checker i_sfa_alu_checker (.*);

// ---- verif/sfa_ctl_model.sv ----
/*
 * Behavioural controller that drives the ALU request and flag-write pins.
 * Assumes one clock; the bench calls its tasks one after another.
 */
`timescale 1ns/1ps
module sfa_ctl_model (
    input wire logic i_clk,
    output logic o_valid,
    output logic [5:0] o_op,
    output logic [15:0] o_a16,
    output logic [15:0] o_b16,
    output logic [31:0] o_a32,
    output logic [31:0] o_b32,
    output logic [15:0] o_cnt,
    output logic o_carry_wr,
    output logic o_carry_val,
    output logic o_ovf_wr,
    output logic o_ovf_val
);
    initial {o_valid, o_op, o_a16, o_b16, o_a32, o_b32, o_cnt, o_carry_wr, o_carry_val, o_ovf_wr, o_ovf_val} = '0;
    // Operands and select change together, held until the taking edge
    task automatic issue(input logic [5:0] op, input logic [15:0] a16, b16, input logic [31:0] a32, b32,
        input logic [15:0] cnt, input logic [3:0] fl);
        @(posedge i_clk);
        #2;
        {o_valid, o_op, o_a16, o_b16, o_a32, o_b32, o_cnt} = {1'b1, op, a16, b16, a32, b32, cnt};
        {o_carry_wr, o_carry_val, o_ovf_wr, o_ovf_val} = fl;
    endtask : issue
    // Released operands show no stale value, so a late sample is caught
    task automatic idle();
        @(posedge i_clk);
        #2;
        {o_valid, o_carry_wr, o_ovf_wr} = '0;
        {o_a16, o_b16, o_a32, o_b32, o_cnt} = ~{o_a16, o_b16, o_a32, o_b32, o_cnt};
    endtask : idle
endmodule : sfa_ctl_model

// ---- verif/sfa_alu_tb.sv ----
/*
 * Self-checking bench for sfa_alu: corner and random requests against a reference.
 * Assumes the controller model drives every request pin.
 */
`timescale 1ns/1ps
module sfa_alu_tb import sfa_pkg::*;;
    typedef struct packed {logic [31:0] res; logic c; logic v;} sfa_note_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wire logic valid, cw, cv, vw, vv, o_valid, o_carry, o_ovf;
    wire logic [5:0] op;
    wire logic [15:0] a16, b16, cnt;
    wire logic [31:0] a32, b32, o_res;
    int seed = 66029;
    int fails = 0;
    int n_compared = 0;
    logic cur_c = 1'b0;
    logic cur_v = 1'b0;
    sfa_note_s q[$];
    sfa_note_s nt;
    logic [15:0] c16 [6] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001, 16'h4000, 16'h0000};
    logic [15:0] ccnt [6] = '{16'h8000, 16'h0010, 16'h0020, 16'h0028, 16'hffd8, 16'h000f};
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    sfa_ctl_model i_sfa_ctl_model (.i_clk(clk), .o_valid(valid), .o_op(op), .o_a16(a16), .o_b16(b16),
        .o_a32(a32), .o_b32(b32), .o_cnt(cnt), .o_carry_wr(cw), .o_carry_val(cv), .o_ovf_wr(vw), .o_ovf_val(vv));
    sfa_alu i_sfa_alu (.i_clk(clk), .i_rst(rst), .i_valid(valid), .i_op(op), .i_a16(a16), .i_b16(b16),
        .i_a32(a32), .i_b32(b32), .i_cnt(cnt), .i_carry_wr(cw), .i_carry_val(cv), .i_ovf_wr(vw),
        .i_ovf_val(vv), .o_valid(o_valid), .o_res(o_res), .o_carry(o_carry), .o_ovf(o_ovf));
    ////////////////////////////////////////////////////////////////////////////
    function automatic longint sat(longint x, int w);
        return x >= (64'sd1 <<< (w - 1)) ? (64'sd1 <<< (w - 1)) - 1 : (x < -(64'sd1 <<< (w - 1)) ?
            -(64'sd1 <<< (w - 1)) : x);
    endfunction : sat
    // Long codes mirror the short ones, so one table of cases serves both widths
    function automatic sfa_note_s model(input logic [5:0] op, input logic [15:0] a16, b16,
        input logic [31:0] a32, b32, input logic [15:0] cnt, output logic f);
        longint x, y, lb, p, fr, c, r;
        logic [32:0] u;
        logic [31:0] m;
        int k, w;
        sfa_note_s n;
        n = '0;
        f = 1'b0;
        k = op >= SFA_OP_ADD32 && op <= SFA_OP_NORM32 ? op - 6'h09 : op >= SFA_OP_AND32 ? op - 6'h05 : op;
        w = k != op ? 32 : 16;
        x = k != op ? $signed(a32) : $signed(a16);
        y = k != op ? $signed(b32) : $signed(b16);
        m = k != op ? a32 : {16'h0000, a16};
        lb = $signed(b32);
        p = $signed(a16) * $signed(b16);
        fr = sat(2 * p, 32);
        c = $signed(cnt);
        r = 0;
        case (k)
            SFA_OP_ADD16: r = sat(x + y, w);
            SFA_OP_SUB16: r = sat(x - y, w);
            SFA_OP_ABS16: r = sat(x < 0 ? -x : x, w);
            SFA_OP_NEG16: r = sat(-x, w);
            SFA_OP_MAX16: r = x > y ? x : y;
            SFA_OP_MIN16: r = x < y ? x : y;
            SFA_OP_SHL16, SFA_OP_SHR16: begin
                c = k == SFA_OP_SHR16 ? -c : c;
                r = sat(c < 0 ? x >>> (c < -63 ? 63 : -c) : x <<< (c > 32 ? 32 : c), w);
            end
            SFA_OP_NORM16: begin
                // Count doublings that still fit the operand width
                for (int i = 0; i < 32 && x != 0 && x * 2 < (64'sd1 <<< (w - 1))
                    && x * 2 >= -(64'sd1 <<< (w - 1)); i++) begin
                    x = x * 2;
                    r++;
                end
            end
            SFA_OP_IMUL16: r = sat(p, 16);
            SFA_OP_MIXED_PRODUCT: r = sat(longint'($signed(a32)) * $signed(b16), 32);
            SFA_OP_FRAC_PRODUCT: r = fr;
            SFA_OP_PLAIN_LONG_PRODUCT: r = p;
            SFA_OP_SCALED_PRODUCT: r = sat(p >>> 15, 16);
            SFA_OP_SCALED_PRODUCT_RND: r = sat((p + 16384) >>> 15, 16);
            SFA_OP_ACCUMULATE: r = sat(lb + fr, 32);
            SFA_OP_DEDUCT: r = sat(lb - fr, 32);
            SFA_OP_PLAIN_ACCUMULATE: r = sat(lb + p, 32);
            SFA_OP_PLAIN_DEDUCT: r = sat(lb - p, 32);
            SFA_OP_WRAPPING_ACCUMULATE_WITH_FLAGS, SFA_OP_WRAPPING_DEDUCT_WITH_FLAGS: begin
                f = 1'b1;
                r = k == SFA_OP_WRAPPING_DEDUCT_WITH_FLAGS ? lb - fr : lb + fr;
                u = {1'b0, b32} + (f && k == SFA_OP_WRAPPING_DEDUCT_WITH_FLAGS ? {1'b0, ~fr[31:0]} + 33'h1 :
                    {1'b0, fr[31:0]});
                n.c = u[32];
                n.v = r != sat(r, 32);
            end
            SFA_OP_ACCUMULATE_RND, SFA_OP_DEDUCT_RND: r = sat(sat(lb + (k == SFA_OP_DEDUCT_RND ? -fr : fr), 32)
                + 32768, 32) >>> 16;
            SFA_OP_AND16: r = x & y;
            SFA_OP_OR16: r = x | y;
            SFA_OP_XOR16: r = x ^ y;
            SFA_OP_LSHL16, SFA_OP_LSHR16: begin
                c = k == SFA_OP_LSHR16 ? -c : c;
                m = c < 0 ? m >> -c : m << c;
                r = k != op ? $signed(m) : $signed(m[15:0]);
            end
            default: r = 0;
        endcase
        n.res = r[31:0];
        return n;
    endfunction : model
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] pk(input logic [15:0] t [6], input int sh);
        int r;
        r = $random(seed);
        return r[2:0] < 3'd6 ? t[r[2:0]] : 16'($signed(r[31:16]) >>> sh);
    endfunction : pk
    task automatic send(input logic [5:0] o, input logic [15:0] x, y, input logic [31:0] lx, ly,
        input logic [15:0] n, input logic [3:0] fl);
        sfa_note_s e;
        logic f;
        e = model(o, x, y, lx, ly, n, f);
        e.c = f ? e.c : (fl[3] ? fl[2] : cur_c);
        e.v = f ? e.v : (fl[1] ? fl[0] : cur_v);
        cur_c = e.c;
        cur_v = e.v;
        q.push_back(e);
        i_sfa_ctl_model.issue(o, x, y, lx, ly, n, fl);
    endtask : send
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (o_valid === 1'b1 && q.size() == 0) begin
            fails++;
            $display("unexpected at %0t: result without request", $time);
        end else if (o_valid === 1'b1) begin
            nt = q.pop_front();
            check({16'h0, o_res[15:0]}, {16'h0, nt.res[15:0]});
            check({16'h0, o_res[31:16]}, {16'h0, nt.res[31:16]});
            check(o_res, nt.res);
            check({30'h0, o_carry, o_ovf}, {30'h0, nt.c, nt.v});
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #2;
        rst = 1'b0;
        check(o_res | {29'h0, o_valid, o_carry, o_ovf}, 32'h0);
        send(SFA_OP_FRAC_PRODUCT, 16'h8000, 16'h8000, 32'h0, 32'h0, 16'h0, 4'h0);
        send(6'h3f, 16'h1234, 16'h0001, 32'h1, 32'h1, 16'h1, 4'hf);
        for (int o = 0; o <= int'(SFA_OP_LSHR32); o++) begin
            for (int j = 0; j < 60; j++) begin
                send(6'(o), pk(c16, 0), pk(c16, 0), {pk(c16, 0), pk(c16, 0)}, {pk(c16, 0), pk(c16, 0)},
                    pk(ccnt, 11), 4'($random(seed)));
                if ($random(seed) % 5 == 0) i_sfa_ctl_model.idle();
            end
        end
        i_sfa_ctl_model.idle();
        for (int t = 0; t < 20 && q.size() > 0; t++) @(posedge clk);
        if (q.size() > 0) begin
            fails++;
            $display("unexpected at %0t: results missing", $time);
        end
        end_of_test();
    end
endmodule : sfa_alu_tb
